/* File: shared/fpuc_pkg.sv */
package fpuc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CFG     = 8'h00;
    localparam logic [7:0] OFS_CMD     = 8'h04;
    localparam logic [7:0] OFS_STAT    = 8'h08;
    localparam logic [7:0] OFS_IMG_PRE = 8'h0c;
    localparam logic [7:0] OFS_IMG_ACC = 8'h10;
    localparam logic [7:0] OFS_HW_ACC  = 8'h14;
    localparam logic [7:0] OFS_HW_PRE  = 8'h18;
    localparam logic [7:0] OFS_FAULT   = 8'h1c;
    // Config fields
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_IE_BIT   = 3;
    // Command bits, write one to act
    localparam int CMD_TRUE  = 0;
    localparam int CMD_FALSE = 1;
    localparam int CMD_RAC   = 2;
    localparam int CMD_RES   = 3;
    localparam int CMD_SVC   = 4;
    localparam int CMD_LDL   = 5;
    localparam int CMD_UA    = 6;
    // Reset values
    localparam logic [2:0]         RST_TYPE    = 3'h0;
    localparam logic signed [15:0] RST_IMG_PRE = 16'sh7fff;
    localparam logic signed [15:0] RST_IMG_ACC = 16'sh0000;
    // Limits and codes
    localparam logic signed [15:0] PRE_MIN       = 16'sh0001;
    localparam logic signed [15:0] ACC_MAX       = 16'sh7fff;
    localparam logic signed [15:0] ACC_MIN       = -16'sh8000;
    localparam logic [7:0]         FAULT_BAD_PRE = 8'h37;
    localparam logic [3:0]         CAUSE_IV      = 4'h8;
    localparam logic [3:0]         CAUSE_IN      = 4'h4;
    localparam logic [3:0]         CAUSE_IH      = 4'h2;

    typedef enum logic [1:0] {
        FPUC_UP,
        FPUC_PD,
        FPUC_UD,
        FPUC_ENC
    } fpuc_kind_t;

    // Status word, bit 15 down to bit 0
    typedef struct packed {
        logic       cu;
        logic       cd;
        logic       done;
        logic       wrap;
        logic       under;
        logic [2:0] rsv;
        logic [3:0] cause;
        logic       pend;
        logic       lost;
        logic       ie;
        logic       cfgd;
    } fpuc_stat_t;

    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] rise;
        logic [3:0] chg;
    } fpuc_pins_t;
endpackage

/* File: design/fpuc_in_edge.sv */
`timescale 1ns/1ps
module fpuc_in_edge (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // Raw pins and conditioned view
    input  wire logic [3:0]            pin_raw,
    output fpuc_pkg::fpuc_pins_t       pins
);
    import fpuc_pkg::*;

    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;

    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_pin
            // Two-stage sync, then history
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_r[i] <= 1'b0;
                    s2_r[i] <= 1'b0;
                    s3_r[i] <= 1'b0;
                end
                else
                begin
                    s1_r[i] <= pin_raw[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                end
            end
        end
    endgenerate

    assign pins = '{lvl: s2_r, rise: s2_r & ~s3_r, chg: s2_r ^ s3_r};
endmodule

/* File: design/fpuc_top.sv */
// Notes on behaviour
// - counter idle after reset until first true setup evaluation
// - false setup condition stops counting only; flags and presets keep working
// - every setup evaluation after configuration copies hardware count to image
// - up types count input 0; reset-hold variant uses input 2 reset, 3 hold
// - pulse/direction counts input 0 rises; input 1 high means down
// - up/down types: input 0 rise increments, input 1 rise decrements
// - encoder types use inputs 0,1 as A,B; variant adds Z reset, hold
// - hold input high blocks all count events while it stays high
// - reset input rising edge zeroes accumulator once configured, ignoring condition and hold; a RAC in the same cycle loads the image count instead
// - bidirectional types keep values at preset; up types clear and reload
// - up types add one per input 0 rise, range 0 to 32767
// - first true setup loads image count and preset into hardware
// - image preset writes reach hardware only at first true setup, up hit, RESET_ACCUMULATOR_CMD, RES or LDL
// - hardware preset must be 1 to 32767, else fault code 37h
// - hardware accumulator takes any signed 16-bit load value
// - preset hit on up step to preset, count load at or above it, preset load at or below count
// - up hit loses no counts, clears both counts, reloads preset
// - up hit sets done and preset cause, or wrap and wrap cause
// - preset hit starts the counter routine only when interrupt enabled
// - status word bits: 15 cu, 13 done, 12 wrap, 7..4 causes
// - pending flag marks waiting routine; new event while pending sets dropped
`timescale 1ns/1ps
module fpuc_top (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Counter inputs
    input  wire logic [3:0]            cnt_in,
    // Events and fault
    output logic                       routine_start,
    output logic      [7:0]            fault_code
);
    import fpuc_pkg::*;

    fpuc_pins_t        pins;
    fpuc_stat_t        stat_r;
    fpuc_kind_t        kind;
    logic [2:0]        type_r;
    logic signed [15:0] acc_r;
    logic signed [15:0] pre_r;
    logic signed [15:0] img_acc_r;
    logic signed [15:0] img_pre_r;
    logic signed [15:0] acc_nxt;
    logic signed [15:0] pre_nxt;
    logic [7:0]        fault_r;
    logic [31:0]       prdata_r;
    logic              pready_r;
    logic              pslverr_r;
    logic              routine_r;
    logic              map_hit;
    logic [31:0]       rd_mux;
    logic              wr_en;
    logic [6:0]        cmd;
    logic              first;
    logic              cfgd;
    logic              has_rh;
    logic              hold;
    logic              rst_edge;
    logic              up_ev;
    logic              dn_ev;
    logic              step_up;
    logic              step_dn;
    logic              acc_ld;
    logic              pre_ld;
    logic              pre_bad;
    logic              hit;
    logic              ovf;
    logic              unf;
    logic              evt;
    logic              up_kind;
    logic              img_pre_ok;

    fpuc_in_edge u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_raw (cnt_in),
        .pins    (pins)
    );

    // Bus decode
    always_comb
    begin
        map_hit = 1'b1;
        rd_mux  = 32'h0000_0000;
        unique case (paddr)
            OFS_CFG:     rd_mux = {28'h0000000, stat_r.ie, type_r};
            OFS_CMD:     rd_mux = 32'h0000_0000;
            OFS_STAT:    rd_mux = {16'h0000, stat_r};
            OFS_IMG_PRE: rd_mux = {16'h0000, img_pre_r};
            OFS_IMG_ACC: rd_mux = {16'h0000, img_acc_r};
            OFS_HW_ACC:  rd_mux = {16'h0000, acc_r};
            OFS_HW_PRE:  rd_mux = {16'h0000, pre_r};
            OFS_FAULT:   rd_mux = {24'h000000, fault_r};
            default:     map_hit = 1'b0;
        endcase
    end

    assign wr_en = psel & penable & pwrite & map_hit;
    assign cmd   = (wr_en && paddr == OFS_CMD) ? pwdata[6:0] : 7'h00;

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= 1'b1;
            if (psel && !penable)
            begin
                prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_r <= !map_hit;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // Mode decode
    assign cfgd    = stat_r.cfgd;
    // wake only on first true setup
    assign first   = cmd[CMD_TRUE] & !cfgd;
    assign kind    = fpuc_kind_t'(type_r[2:1]);
    assign up_kind = (kind == FPUC_UP);
    assign has_rh  = type_r[0];
    assign hold    = has_rh & pins.lvl[3];
    // reset edge ignores condition and hold
    assign rst_edge = cfgd & has_rh & pins.rise[2];
    assign img_pre_ok = (img_pre_r >= PRE_MIN);

    // Count event per type
    always_comb
    begin
        up_ev = 1'b0;
        dn_ev = 1'b0;
        unique case (kind)
            FPUC_UP:  up_ev = pins.rise[0];
            FPUC_PD:
            begin
                up_ev = pins.rise[0] & !pins.lvl[1];
                dn_ev = pins.rise[0] & pins.lvl[1];
            end
            FPUC_UD:
            begin
                up_ev = pins.rise[0];
                dn_ev = pins.rise[1];
            end
            FPUC_ENC:
            begin
                // A on input 0, B on input 1
                // one count per A rise, skip A and B together
                up_ev = pins.rise[0] & !pins.chg[1] & !pins.lvl[1];
                dn_ev = pins.rise[0] & !pins.chg[1] & pins.lvl[1];
            end
        endcase
    end

    assign step_up = cfgd & stat_r.cu & !hold & up_ev & !dn_ev;
    assign step_dn = cfgd & stat_r.cu & !hold & dn_ev & !up_ev;

    // Next count and preset
    always_comb
    begin
        acc_nxt = acc_r;
        pre_nxt = pre_r;
        acc_ld  = 1'b0;
        pre_ld  = 1'b0;
        pre_bad = 1'b0;
        hit     = 1'b0;
        ovf     = 1'b0;
        unf     = 1'b0;
        if (first || (cfgd && (cmd[CMD_RAC] || cmd[CMD_RES] || rst_edge)))
        begin
            acc_ld  = 1'b1;
            acc_nxt = (first || cmd[CMD_RAC]) ? img_acc_r : 16'sh0000;
        end
        else if (step_up)
        begin
            acc_nxt = acc_r + 16'sh0001;
            ovf     = !up_kind && (acc_r == ACC_MAX);
        end
        else if (step_dn)
        begin
            acc_nxt = acc_r - 16'sh0001;
            unf     = !up_kind && (acc_r == ACC_MIN);
        end
        // preset reaches hardware on first true setup and load commands, or on up hit below
        if (first || (cfgd && (cmd[CMD_RAC] || cmd[CMD_RES] || cmd[CMD_LDL])))
        begin
            if (img_pre_ok)
            begin
                pre_ld  = 1'b1;
                pre_nxt = img_pre_r;
            end
            else
            begin
                pre_bad = 1'b1;
            end
        end
        hit = (step_up && !acc_ld && acc_nxt == pre_nxt)
            || (acc_ld && acc_nxt >= pre_nxt)
            || (pre_ld && pre_nxt <= acc_nxt);
        // only up types clear and reload
        if (hit && up_kind)
        begin
            acc_nxt = 16'sh0000;
            if (img_pre_ok)
            begin
                pre_nxt = img_pre_r;
            end
            else
            begin
                pre_bad = 1'b1;
            end
        end
    end

    assign evt = hit | ovf | unf;

    // Hardware count and preset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_r <= 16'sh0000;
            pre_r <= 16'sh0000;
        end
        else
        begin
            acc_r <= acc_nxt;
            pre_r <= pre_nxt;
        end
    end

    // Image registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            img_acc_r <= RST_IMG_ACC;
            img_pre_r <= RST_IMG_PRE;
        end
        else
        begin
            if (cfgd && (cmd[CMD_TRUE] || cmd[CMD_FALSE] || cmd[CMD_UA]))
            begin
                img_acc_r <= acc_nxt;
            end
            else if (hit && up_kind)
            begin
                img_acc_r <= 16'sh0000;
            end
            else if (wr_en && paddr == OFS_IMG_ACC)
            begin
                img_acc_r <= pwdata[15:0];
            end
            if (wr_en && paddr == OFS_IMG_PRE)
            begin
                img_pre_r <= pwdata[15:0];
            end
        end
    end

    // Type and fault
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            type_r  <= RST_TYPE;
            fault_r <= 8'h00;
        end
        else
        begin
            if (wr_en && paddr == OFS_CFG && !cfgd)
            begin
                type_r <= pwdata[CFG_TYPE_LSB +: 3];
            end
            if (pre_bad)
            begin
                fault_r <= FAULT_BAD_PRE;
            end
            else if (wr_en && paddr == OFS_FAULT)
            begin
                fault_r <= 8'h00;
            end
        end
    end

    assign fault_code = fault_r;

    // Status flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_r <= '0;
        end
        else
        begin
            if (cmd[CMD_TRUE] || cmd[CMD_FALSE])
            begin
                stat_r.cu <= cmd[CMD_TRUE];
                stat_r.cd <= cmd[CMD_TRUE] & !up_kind;
            end
            if (first)
            begin
                stat_r.cfgd  <= 1'b1;
                stat_r.ie    <= 1'b1;
                stat_r.cause <= 4'h0;
                stat_r.pend  <= 1'b0;
            end
            else if (wr_en && paddr == OFS_CFG)
            begin
                stat_r.ie <= pwdata[CFG_IE_BIT];
            end
            if (wr_en && paddr == OFS_STAT)
            begin
                if (pwdata[13]) stat_r.done <= 1'b0;
                if (pwdata[12]) stat_r.wrap <= 1'b0;
                if (pwdata[11]) stat_r.under <= 1'b0;
                if (pwdata[2]) stat_r.lost <= 1'b0;
            end
            if (cfgd && (cmd[CMD_RAC] || cmd[CMD_RES]))
            begin
                stat_r.done  <= 1'b0;
                stat_r.wrap  <= 1'b0;
                stat_r.under <= 1'b0;
                stat_r.pend  <= 1'b0;
                stat_r.lost  <= 1'b0;
            end
            else if (cmd[CMD_SVC])
            begin
                stat_r.pend <= 1'b0;
            end
            if (hit && up_kind)
            begin
                if (!stat_r.done)
                begin
                    stat_r.done  <= 1'b1;
                    stat_r.cause <= CAUSE_IH;
                end
                else
                begin
                    stat_r.wrap  <= 1'b1;
                    stat_r.cause <= CAUSE_IV;
                end
            end
            else if (hit)
            begin
                stat_r.cause <= CAUSE_IH;
            end
            if (ovf)
            begin
                stat_r.wrap  <= 1'b1;
                stat_r.cause <= CAUSE_IV;
            end
            if (unf)
            begin
                stat_r.under <= 1'b1;
                stat_r.cause <= CAUSE_IN;
            end
            if (evt && stat_r.ie)
            begin
                stat_r.pend <= 1'b1;
                if (stat_r.pend)
                begin
                    stat_r.lost <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            routine_r <= 1'b0;
        end
        else
        begin
            routine_r <= evt & stat_r.ie;
        end
    end

    assign routine_start = routine_r;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    idle_before_cfg_a: assert property ((!cfgd && !first) |=> $stable(acc_r))
        else $error("count moved before configuration");
    cond_false_a: assert property ((cfgd && !stat_r.cu && !acc_ld && !pre_ld)
        |=> $stable(acc_r))
        else $error("count moved with false condition");
    img_copy_a: assert property ((cfgd && cmd[CMD_TRUE]) |=> img_acc_r == acc_r)
        else $error("image count not refreshed");
    up_step_a: assert property ((step_up && up_kind && !hit)
        |=> acc_r == $past(acc_r) + 16'sh0001)
        else $error("up count did not add one");
    hold_block_a: assert property ((hold && !acc_ld && !pre_ld && !hit)
        |=> $stable(acc_r))
        else $error("count moved while held");
    rst_input_a: assert property ((rst_edge && !cmd[CMD_RAC]) |=> acc_r == 16'sh0000)
        else $error("reset edge did not zero count");
    bad_pre_a: assert property (pre_bad |=> fault_r == FAULT_BAD_PRE && $stable(pre_r))
        else $error("invalid preset not faulted");
    up_hit_a: assert property ((hit && up_kind) |=> acc_r == 16'sh0000
        && img_acc_r == 16'sh0000)
        else $error("up hit did not clear counts");
    wrap_cause_a: assert property ((hit && up_kind && stat_r.done)
        |=> stat_r.wrap && stat_r.cause == CAUSE_IV)
        else $error("second hit did not set wrap");
    lost_evt_a: assert property ((evt && stat_r.ie && stat_r.pend) |=> stat_r.lost)
        else $error("dropped event not flagged");
    routine_a: assert property (hit |=> routine_start == $past(stat_r.ie))
        else $error("routine start mismatch");
endmodule

/* File: sim/fpuc_pulse_src.sv */
`timescale 1ns/1ps
module fpuc_pulse_src (
    // Clock
    input  wire logic       pclk,
    // Pins towards the counter
    output logic      [3:0] pins
);
    initial pins = 4'h0;
    // Each level stands three cycles
    task automatic level(input int i, input logic v);
        @(posedge pclk);
        pins[i] <= v;
        repeat (2) @(posedge pclk);
    endtask
    task automatic pulse(input int i, input int n);
        repeat (n)
        begin
            level(i, 1'b1);
            level(i, 1'b0);
        end
    endtask
    task automatic quad(input logic up, input int n);
        repeat (n)
        begin
            level(up ? 0 : 1, 1'b1);
            level(up ? 1 : 0, 1'b1);
            level(up ? 0 : 1, 1'b0);
            level(up ? 1 : 0, 1'b0);
        end
    endtask
endmodule

/* File: sim/tb_fast_pulse_up_counter.sv */
`timescale 1ns/1ps
module tb_fast_pulse_up_counter;
    import fpuc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, routine_start;
    logic [3:0]  cnt_in;
    logic [7:0]  fault_code;
    int          bad_count = 0, checked = 0, rs_cnt = 0, cyc = 0, rs0;

    fpuc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cnt_in(cnt_in), .routine_start(routine_start),
        .fault_code(fault_code));
    fpuc_pulse_src src (.pclk(pclk), .pins(cnt_in));

    always #12.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (routine_start === 1'b1)
            rs_cnt <= rs_cnt + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    task automatic cmd(input int b);
        wr(OFS_CMD, 32'h1 << b);
        repeat (4) @(posedge pclk);
    endtask
    task automatic cfg(input logic [2:0] t, input logic [15:0] pre, input logic [15:0] acc);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wr(OFS_CFG, {29'h0, t});
        wr(OFS_IMG_PRE, {16'h0, pre});
        wr(OFS_IMG_ACC, {16'h0, acc});
        cmd(CMD_TRUE);
    endtask

    task automatic t_idle();
        src.pulse(0, 2);
        rd("hw_acc", OFS_HW_ACC, 32'h0);
        rd("hw_pre", OFS_HW_PRE, 32'h0);
        rd("img_pre", OFS_IMG_PRE, 32'h7fff);
        rd("stat", OFS_STAT, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 1, rerr);
    endtask
    task automatic t_up_hit();
        cfg(3'h0, 16'h3, 16'h1);
        rd("hw_pre", OFS_HW_PRE, 32'h3);
        rd("hw_acc", OFS_HW_ACC, 32'h1);
        src.pulse(0, 2);
        rd("hw_acc", OFS_HW_ACC, 32'h0);
        rd("img_acc", OFS_IMG_ACC, 32'h0);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("done", 1, rdat[13]);
        chk("cause", 4'h2, rdat[7:4]);
        chk("pend", 1, rdat[3]);
        chk("routine", 1, rs_cnt);
    endtask
    task automatic t_wrap();
        wr(OFS_IMG_PRE, 32'h2);
        rd("hw_pre", OFS_HW_PRE, 32'h3);
        src.pulse(0, 3);
        rd("hw_pre", OFS_HW_PRE, 32'h2);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("wrap", 1, rdat[12]);
        chk("cause", 4'h8, rdat[7:4]);
        chk("dropped", 1, rdat[2]);
        cmd(CMD_SVC);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("pend", 0, rdat[3]);
    endtask
    task automatic t_false();
        src.pulse(0, 1);
        src.pulse(2, 1);
        rd("hw_acc", OFS_HW_ACC, 32'h1);
        cmd(CMD_FALSE);
        rd("img_acc", OFS_IMG_ACC, 32'h1);
        src.pulse(0, 1);
        rd("hw_acc", OFS_HW_ACC, 32'h1);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("cu", 0, rdat[15]);
        cmd(CMD_TRUE);
    endtask
    task automatic t_bad_pre();
        wr(OFS_IMG_PRE, 32'h0);
        cmd(CMD_RES);
        chk("fault", 8'h37, fault_code);
        rd("hw_pre", OFS_HW_PRE, 32'h2);
        rd("hw_acc", OFS_HW_ACC, 32'h0);
        wr(OFS_FAULT, 32'h0);
        @(posedge pclk);
        chk("fault", 8'h0, fault_code);
    endtask
    task automatic t_load_hit();
        rs0 = rs_cnt;
        wr(OFS_IMG_PRE, 32'h4);
        wr(OFS_IMG_ACC, 32'h6);
        cmd(CMD_RAC);
        rd("hw_acc", OFS_HW_ACC, 32'h0);
        rd("hw_pre", OFS_HW_PRE, 32'h4);
        chk("routine", rs0 + 1, rs_cnt);
        wr(OFS_CFG, 32'h0);
        wr(OFS_IMG_ACC, 32'h6);
        rs0 = rs_cnt;
        cmd(CMD_RAC);
        rd("hw_acc", OFS_HW_ACC, 32'h0);
        chk("routine_off", rs0, rs_cnt);
    endtask
    task automatic t_reset_hold();
        cfg(3'h1, 16'd100, 16'h0);
        src.pulse(0, 2);
        src.level(3, 1'b1);
        src.pulse(0, 2);
        rd("hw_acc", OFS_HW_ACC, 32'h2);
        src.level(3, 1'b0);
        src.pulse(2, 1);
        rd("hw_acc", OFS_HW_ACC, 32'h0);
    endtask
    task automatic t_bidir();
        cfg(3'h4, 16'h3, 16'h0);
        src.pulse(0, 2);
        src.pulse(1, 1);
        rd("hw_acc", OFS_HW_ACC, 32'h1);
        src.pulse(0, 2);
        rd("hw_acc", OFS_HW_ACC, 32'h3);
        cfg(3'h2, 16'd100, 16'h8000);
        rd("hw_acc", OFS_HW_ACC, 32'h8000);
        src.pulse(0, 2);
        src.level(1, 1'b1);
        src.pulse(0, 3);
        src.level(1, 1'b0);
        rd("hw_acc", OFS_HW_ACC, 32'h7fff);
        cfg(3'h7, 16'd100, 16'h0);
        src.quad(1'b1, 3);
        src.quad(1'b0, 1);
        rd("hw_acc", OFS_HW_ACC, 32'h2);
        src.pulse(2, 1);
        rd("hw_acc", OFS_HW_ACC, 32'h0);
    endtask

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_idle();
        t_up_hit();
        t_wrap();
        t_false();
        t_bad_pre();
        t_load_hit();
        t_reset_hold();
        t_bidir();
        end_of_test();
    end
endmodule
